// ### logic/sbi_pkg.sv
// types shared by the secure bypass register bank
// assumes the constants header is compiled alongside
package sbi_pkg;

  // -----------------------------------------------------------------------
  // transaction attributes
  // -----------------------------------------------------------------------
  typedef struct packed {
    logic instr;
    logic priv;
    logic non_secure;
    logic [1:0] share;
    logic [3:0] mem_type;
    logic read_allocate_hint;
    logic write_allocate_hint;
    logic transient_hint;
  } sbi_attr_t;

  typedef struct packed {
    logic secure_stream;
    logic is_write;
    sbi_attr_t attr;
  } sbi_txn_in_t;

  typedef struct packed {
    logic abort;
    logic bypassed;
    sbi_attr_t attr;
    logic [31:0] implementation_tag;
  } sbi_txn_out_t;

  typedef enum logic {
    SBI_UPD_IDLE,
    SBI_UPD_APPLY
  } sbi_upd_state_t;

endpackage

// ### logic/sbi_regs.svh
// register offsets, field positions, reset values and codes of the secure
// bypass register bank; definitions only, included by its bare name
`ifndef SBI_REGS_SVH
`define SBI_REGS_SVH

// -------------------------------------------------------------------------
// offsets (byte addresses on the memory-mapped port)
// -------------------------------------------------------------------------
`define SBI_ADDR_W 16
`define SBI_OFF_BYPASS 16'h8044
`define SBI_OFF_ALT_TAG 16'h8048
`define SBI_OFF_IRQ_EN 16'h8050
`define SBI_OFF_IRQ_ACK 16'h8054

// -------------------------------------------------------------------------
// bypass attribute fields
// -------------------------------------------------------------------------
`define SBI_BP_UPDATE 31
`define SBI_BP_ABORT 20
`define SBI_BP_INSTR_HI 19
`define SBI_BP_INSTR_LO 18
`define SBI_BP_PRIV_HI 17
`define SBI_BP_PRIV_LO 16
`define SBI_BP_SEC_HI 15
`define SBI_BP_SEC_LO 14
`define SBI_BP_SH_HI 13
`define SBI_BP_SH_LO 12
`define SBI_BP_ALLOC_EN 11
`define SBI_BP_ALLOC_R 10
`define SBI_BP_ALLOC_W 9
`define SBI_BP_ALLOC_T 8
`define SBI_BP_MT_EN 4
`define SBI_BP_MATTR_HI 3
`define SBI_BP_MATTR_LO 0
`define SBI_BP_WMASK 32'h801f_ff1f
// abort set for deny-by-default, shareability keeps incoming, rest zero
`define SBI_BP_RESET 32'h0010_1000

// -------------------------------------------------------------------------
// interrupt enable fields
// -------------------------------------------------------------------------
`define SBI_IRQ_EVQ 2
`define SBI_IRQ_GERR 0
`define SBI_IRQ_WMASK 32'h0000_0005
`define SBI_IRQ_RESET 32'h0000_0000
`define SBI_ALT_RESET 32'h0000_0000

// -------------------------------------------------------------------------
// override codes and memory types
// -------------------------------------------------------------------------
`define SBI_OVR_FORCE_A 2'b10
`define SBI_OVR_FORCE_B 2'b11
`define SBI_SH_NON 2'b00
`define SBI_SH_KEEP 2'b01
`define SBI_SH_OUTER 2'b10
`define SBI_SH_INNER 2'b11
`define SBI_MT_NORMAL_WB 4'hf
`define SBI_MT_NORMAL_WT 4'ha

`endif

// ### logic/sbi_secure_bypass.sv
// secure bypass attribute, alternate tag and interrupt enable registers,
// plus the bypass attribute path for secure stream transactions
// assumes all inputs come from logic on i_core_clk; one access per request
`timescale 1ns/1ps
`include "sbi_regs.svh"

module sbi_secure_bypass (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_secure,
  input wire logic [`SBI_ADDR_W-1:0] i_req_addr,
  input wire logic [31:0] i_req_wdata,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_rdata,
  input wire logic i_translation_enable,
  input wire logic i_attribute_override_capable,
  input wire logic i_txn_valid,
  input wire sbi_pkg::sbi_txn_in_t i_txn,
  output logic o_txn_valid,
  output sbi_pkg::sbi_txn_out_t o_txn,
  output logic o_event_queue_irq_enable,
  output logic o_global_error_irq_enable
);

  // -----------------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------------
  logic [31:0] bypass_reg;
  logic [31:0] next_bypass_reg;
  logic [31:0] bypass_live;
  logic [31:0] next_bypass_live;
  logic [31:0] alt_tag;
  logic [31:0] next_alt_tag;
  logic [31:0] irq_en;
  logic [31:0] next_irq_en;
  logic [31:0] irq_ack;
  logic [31:0] next_irq_ack;
  sbi_pkg::sbi_upd_state_t upd_state;
  sbi_pkg::sbi_upd_state_t next_upd_state;
  logic wr_ok;
  logic rd_ok;
  logic wr_alt_tag;
  logic wr_irq_en;

  // -----------------------------------------------------------------------
  // request decode
  // -----------------------------------------------------------------------
  // non-secure requests neither store nor see anything
  always_comb begin
    wr_ok = i_req_valid && i_req_write && i_req_secure;
    rd_ok = i_req_valid && !i_req_write && i_req_secure;
    // the acknowledge offset and unmapped offsets decode to no store at all
    wr_alt_tag = wr_ok && i_req_addr == `SBI_OFF_ALT_TAG;
    wr_irq_en = wr_ok && i_req_addr == `SBI_OFF_IRQ_EN;
  end

  // -----------------------------------------------------------------------
  // bypass attribute update sequencing
  // -----------------------------------------------------------------------
  // readback and live set are kept apart so that a write without the
  // update flag never disturbs traffic already in flight
  always_comb begin
    next_bypass_reg = bypass_reg;
    next_bypass_live = bypass_live;
    next_upd_state = upd_state;
    unique case (upd_state)
      sbi_pkg::SBI_UPD_IDLE: begin
        // writes land only while no update is outstanding
        if (wr_ok && i_req_addr == `SBI_OFF_BYPASS
            && !bypass_reg[`SBI_BP_UPDATE]) begin
          next_bypass_reg = i_req_wdata & `SBI_BP_WMASK;
          if (i_req_wdata[`SBI_BP_UPDATE]) begin
            next_upd_state = sbi_pkg::SBI_UPD_APPLY;
          end
        end
      end
      sbi_pkg::SBI_UPD_APPLY: begin
        // the path switches to the new set here, on the same edge as the flag drops
        next_bypass_live = bypass_reg;
        next_bypass_reg[`SBI_BP_UPDATE] = 1'b0;
        next_upd_state = sbi_pkg::SBI_UPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      bypass_reg <= `SBI_BP_RESET;
      bypass_live <= `SBI_BP_RESET;
      upd_state <= sbi_pkg::SBI_UPD_IDLE;
    end else begin
      bypass_reg <= next_bypass_reg;
      bypass_live <= next_bypass_live;
      upd_state <= next_upd_state;
    end
  end

  // -----------------------------------------------------------------------
  // alternate bypass tag
  // -----------------------------------------------------------------------
  // plain storage; a new tag reaches bypassed traffic on the next edge,
  // without waiting for an attribute update
  always_comb begin
    next_alt_tag = alt_tag;
    if (wr_alt_tag) begin
      next_alt_tag = i_req_wdata;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      alt_tag <= `SBI_ALT_RESET;
    end else begin
      alt_tag <= next_alt_tag;
    end
  end

  // -----------------------------------------------------------------------
  // interrupt enables and acknowledge
  // -----------------------------------------------------------------------
  always_comb begin
    next_irq_en = irq_en;
    if (wr_irq_en) begin
      next_irq_en = i_req_wdata & `SBI_IRQ_WMASK;
    end
    // acknowledge catches up one cycle after the enable is stored,
    // the same edge at which the enable outputs change
    next_irq_ack = irq_en & `SBI_IRQ_WMASK;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      irq_en <= `SBI_IRQ_RESET;
      irq_ack <= `SBI_IRQ_RESET;
    end else begin
      irq_en <= next_irq_en;
      irq_ack <= next_irq_ack;
    end
  end

  // -----------------------------------------------------------------------
  // read response
  // -----------------------------------------------------------------------
  logic next_rsp_valid;
  logic [31:0] next_rsp_rdata;

  always_comb begin
    next_rsp_valid = i_req_valid;
    next_rsp_rdata = 32'h0000_0000;
    if (rd_ok) begin
      unique case (i_req_addr)
        `SBI_OFF_BYPASS: next_rsp_rdata = bypass_reg;
        `SBI_OFF_ALT_TAG: next_rsp_rdata = alt_tag;
        `SBI_OFF_IRQ_EN: next_rsp_rdata = irq_en;
        `SBI_OFF_IRQ_ACK: next_rsp_rdata = irq_ack;
        default: next_rsp_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= 32'h0000_0000;
    end else begin
      o_rsp_valid <= next_rsp_valid;
      o_rsp_rdata <= next_rsp_rdata;
    end
  end

  // -----------------------------------------------------------------------
  // interrupt enable outputs
  // -----------------------------------------------------------------------
  logic next_event_queue_irq_enable;
  logic next_global_error_irq_enable;

  // outputs move on the same edge as the acknowledge, so software that
  // polls the acknowledge never sees it ahead of the enable in effect
  always_comb begin
    next_event_queue_irq_enable = irq_en[`SBI_IRQ_EVQ];
    next_global_error_irq_enable = irq_en[`SBI_IRQ_GERR];
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_event_queue_irq_enable <= 1'b0;
      o_global_error_irq_enable <= 1'b0;
    end else begin
      o_event_queue_irq_enable <= next_event_queue_irq_enable;
      o_global_error_irq_enable <= next_global_error_irq_enable;
    end
  end

  // -----------------------------------------------------------------------
  // bypass attribute path
  // -----------------------------------------------------------------------
  sbi_pkg::sbi_txn_out_t next_txn;
  sbi_pkg::sbi_attr_t attr;
  logic bypass;
  logic [1:0] instr_data_override;
  logic [1:0] privilege_override;
  logic [1:0] security_override;
  logic [1:0] shareability_override;
  logic [3:0] allocation_hint_override;
  logic cacheable;
  logic instr_pick;
  logic priv_pick;
  logic sec_pick;

  // -----------------------------------------------------------------------
  // override decoders
  // -----------------------------------------------------------------------
  // the instruction, privilege and security overrides each have their own instance of the keep/force decoder
  sbi_ovr_pick u_instr_pick (
    .i_code(instr_data_override),
    .i_incoming(i_txn.attr.instr),
    .o_value(instr_pick)
  );

  sbi_ovr_pick u_priv_pick (
    .i_code(privilege_override),
    .i_incoming(i_txn.attr.priv),
    .o_value(priv_pick)
  );

  sbi_ovr_pick u_sec_pick (
    .i_code(security_override),
    .i_incoming(i_txn.attr.non_secure),
    .o_value(sec_pick)
  );

  // the path is one register deep so that o_txn lines up with o_txn_valid;
  // attributes are computed every cycle, valid or not

  always_comb begin
    instr_data_override = bypass_live[`SBI_BP_INSTR_HI:`SBI_BP_INSTR_LO];
    privilege_override = bypass_live[`SBI_BP_PRIV_HI:`SBI_BP_PRIV_LO];
    // readback keeps the written value, the path ignores it if incapable
    security_override = i_attribute_override_capable
        ? bypass_live[`SBI_BP_SEC_HI:`SBI_BP_SEC_LO] : 2'b00;
    shareability_override = bypass_live[`SBI_BP_SH_HI:`SBI_BP_SH_LO];
    allocation_hint_override = bypass_live[`SBI_BP_ALLOC_EN:`SBI_BP_ALLOC_T];
    bypass = i_txn.secure_stream && !i_translation_enable;
    attr = i_txn.attr;
    if (bypass) begin
      if (bypass_live[`SBI_BP_MT_EN]) begin
        attr.mem_type = bypass_live[`SBI_BP_MATTR_HI:`SBI_BP_MATTR_LO];
      end
      // writes carry no instruction meaning, so the override skips them
      if (i_txn.is_write) begin
        attr.instr = 1'b0;
      end else begin
        attr.instr = instr_pick;
      end
      attr.priv = priv_pick;
      attr.non_secure = sec_pick;
      unique case (shareability_override)
        `SBI_SH_NON: attr.share = `SBI_SH_NON;
        `SBI_SH_KEEP: attr.share = i_txn.attr.share;
        `SBI_SH_OUTER: attr.share = `SBI_SH_OUTER;
        `SBI_SH_INNER: attr.share = `SBI_SH_INNER;
      endcase
    end
    // hints only mean something for cacheable normal memory
    cacheable = attr.mem_type == `SBI_MT_NORMAL_WB
        || attr.mem_type == `SBI_MT_NORMAL_WT;
    if (bypass && cacheable && allocation_hint_override[3]) begin
      attr.read_allocate_hint = allocation_hint_override[2];
      attr.write_allocate_hint = allocation_hint_override[1];
      attr.transient_hint = allocation_hint_override[0];
    end
    next_txn.attr = attr;
    next_txn.bypassed = bypass;
    next_txn.abort = bypass && bypass_live[`SBI_BP_ABORT];
    next_txn.implementation_tag = bypass ? alt_tag : 32'h0000_0000;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_txn_valid <= 1'b0;
      o_txn <= '0;
    end else begin
      o_txn_valid <= i_txn_valid;
      o_txn <= next_txn;
    end
  end

endmodule

// -------------------------------------------------------------------------
// two-bit override decoder
// -------------------------------------------------------------------------
// codes 00 and 01 both keep the incoming value; the reserved code is
// treated as keep rather than trapped, so no code is illegal here
module sbi_ovr_pick #(
  parameter logic FORCE_A_VALUE = 1'b0
) (
  input wire logic [1:0] i_code,
  input wire logic i_incoming,
  output logic o_value
);

  always_comb begin
    unique case (i_code)
      `SBI_OVR_FORCE_A: o_value = FORCE_A_VALUE;
      `SBI_OVR_FORCE_B: o_value = !FORCE_A_VALUE;
      default: o_value = i_incoming;
    endcase
  end

endmodule

// ### tb/sbi_checker.sv
// concurrent checks on the secure bypass register bank ports
// assumes one clock and a synchronous active-high reset; bound below
`timescale 1ns/1ps
`include "sbi_regs.svh"
module sbi_checker (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_secure,
  input wire logic [`SBI_ADDR_W-1:0] i_req_addr,
  input wire logic [31:0] i_req_wdata,
  input wire logic o_rsp_valid,
  input wire logic [31:0] o_rsp_rdata,
  input wire logic i_translation_enable,
  input wire logic i_txn_valid,
  input wire sbi_pkg::sbi_txn_in_t i_txn,
  input wire logic o_txn_valid,
  input wire sbi_pkg::sbi_txn_out_t o_txn,
  input wire logic o_event_queue_irq_enable,
  input wire logic o_global_error_irq_enable
);
  // -----------------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  wire logic sec_rd = i_req_valid && i_req_secure && !i_req_write;
  wire logic byp = i_txn_valid && i_txn.secure_stream && !i_translation_enable;
  ns_read_zero_a: assert property (
    i_req_valid && !i_req_secure |=> o_rsp_valid && o_rsp_rdata == 32'h0)
    else $error("non-secure access returned data");
  ack_mirror_a: assert property (sec_rd && i_req_addr == `SBI_OFF_IRQ_ACK |=>
    o_rsp_rdata == {29'h0, $past(o_event_queue_irq_enable), 1'b0,
    $past(o_global_error_irq_enable)}) else $error("ack read mismatch");
  bypass_reserved_a: assert property (sec_rd && i_req_addr == `SBI_OFF_BYPASS |=>
    (o_rsp_rdata & ~`SBI_BP_WMASK) == 32'h0) else $error("bypass reserved bits set");
  evq_lag_a: assert property ($changed(o_event_queue_irq_enable) |->
    $past(i_req_valid && i_req_secure && i_req_write && i_req_addr == `SBI_OFF_IRQ_EN, 2)
    && o_event_queue_irq_enable == $past(i_req_wdata[2], 2)) else $error("evq enable moved");
  gerr_lag_a: assert property ($changed(o_global_error_irq_enable) |->
    $past(i_req_valid && i_req_secure && i_req_write && i_req_addr == `SBI_OFF_IRQ_EN, 2)
    && o_global_error_irq_enable == $past(i_req_wdata[0], 2)) else $error("gerr enable moved");
  no_bypass_a: assert property (i_txn_valid && !byp |=> o_txn_valid &&
    !o_txn.bypassed && !o_txn.abort && o_txn.attr == $past(i_txn.attr))
    else $error("unbypassed txn altered");
  bypass_on_a: assert property (byp |=> o_txn_valid && o_txn.bypassed)
    else $error("secure txn not bypassed");
  write_data_a: assert property (byp && i_txn.is_write |=>
    o_txn.abort || !o_txn.attr.instr) else $error("bypassed write not data");
  cover property (o_txn_valid && o_txn.abort);
  cover property (o_txn_valid && o_txn.bypassed && !o_txn.abort);
  cover property ($rose(o_event_queue_irq_enable));
endmodule
bind sbi_secure_bypass sbi_checker u_chk (.*);

// ### tb/sbi_txn_src.sv
// upstream master model: issues one transaction on request
// assumes i_go and i_txn settle before the next rising edge
`timescale 1ns/1ps
module sbi_txn_src (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire sbi_pkg::sbi_txn_in_t i_txn,
  output logic o_txn_valid,
  output sbi_pkg::sbi_txn_in_t o_txn
);
  // idle cycles show the inverse so stale attributes cannot pass a check
  initial begin
    o_txn_valid = 1'b0;
    o_txn = '0;
  end
  always @(posedge i_core_clk) begin
    o_txn_valid <= #1 i_go;
    o_txn <= #1 (i_go ? i_txn : ~o_txn);
  end
endmodule

// ### tb/testbench.sv
// self-checking bench for the secure bypass register bank
// assumes the package and constants header are compiled first
`timescale 1ns/1ps
`include "sbi_regs.svh"
module testbench;
  logic clk = 1'b0, srst = 1'b1, rv = 1'b0, rw = 1'b0, rs = 1'b0;
  logic te = 1'b0, cap = 1'b1, go = 1'b0, rspv, tv, eqe, gee, sv;
  logic [15:0] ra = 16'h0;
  logic [31:0] wd = 32'h0, rd, got;
  sbi_pkg::sbi_txn_in_t ti = '0, si;
  sbi_pkg::sbi_txn_out_t to;
  sbi_pkg::sbi_txn_in_t tin [5] = '{14'h26a0, 14'h3810, 14'h2b22, 14'h23d1, 14'h3810};
  logic [31:0] bps [5] = '{32'h000e_ad1f, 32'h000f_f51a, 32'h0005_5f04, 32'h0000_0e00,
    32'h000f_f51a};
  int err_total = 0, check_count = 0;
  initial forever #25 clk = ~clk;
  sbi_txn_src u_src (.i_core_clk(clk), .i_go(go), .i_txn(ti), .o_txn_valid(sv), .o_txn(si));
  sbi_secure_bypass u_dut (.i_core_clk(clk), .i_srst(srst), .i_req_valid(rv), .i_req_write(rw),
    .i_req_secure(rs), .i_req_addr(ra), .i_req_wdata(wd), .o_rsp_valid(rspv), .o_rsp_rdata(rd),
    .i_translation_enable(te), .i_attribute_override_capable(cap), .i_txn_valid(sv),
    .i_txn(si), .o_txn_valid(tv), .o_txn(to), .o_event_queue_irq_enable(eqe),
    .o_global_error_irq_enable(gee));
  // -----------------------------------------------------------------------
  // access tasks and reference model
  // -----------------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (e !== g) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic s, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 {rv, rw, rs, ra, wd} = {1'b1, w, s, a, d};
    @(posedge clk);
    #1 rv = 1'b0;
    chk("rsp_valid", 32'h1, {31'h0, rspv});
    got = rd;
  endtask
  task automatic rchk(input string n, input logic [15:0] a, input logic [31:0] e);
    acc(1'b0, 1'b1, a, 32'h0);
    chk(n, e, got);
  endtask
  // one transaction: partner adds a cycle, the block another
  task automatic xfer(input sbi_pkg::sbi_txn_in_t t);
    @(posedge clk);
    #1 {go, ti} = {1'b1, t};
    @(posedge clk);
    #1 go = 1'b0;
    @(posedge clk);
    #1 chk("txn_valid", 32'h1, {31'h0, tv});
  endtask
  function automatic sbi_pkg::sbi_attr_t exp_attr(input logic [31:0] b,
    input sbi_pkg::sbi_txn_in_t t, input logic c);
    sbi_pkg::sbi_attr_t a;
    a = t.attr;
    if (t.is_write) a.instr = 1'b0;
    else if (b[19]) a.instr = b[18];
    if (b[17]) a.priv = b[16];
    if (b[15] && c) a.non_secure = b[14];
    if (b[13:12] != 2'b01) a.share = b[13:12];
    if (b[4]) a.mem_type = b[3:0];
    if (b[11] && (a.mem_type == 4'hf || a.mem_type == 4'ha))
      {a.read_allocate_hint, a.write_allocate_hint, a.transient_hint} = b[10:8];
    return a;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #5000000;
    err_total++;
    final_report;
  end
  // -----------------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    rchk("bypass_rst", `SBI_OFF_BYPASS, `SBI_BP_RESET);
    rchk("alt_rst", `SBI_OFF_ALT_TAG, 32'h0);
    rchk("irq_rst", `SBI_OFF_IRQ_EN, 32'h0);
    rchk("ack_rst", `SBI_OFF_IRQ_ACK, 32'h0);
    rchk("unmapped", 16'h8058, 32'h0);
    acc(1'b1, 1'b1, `SBI_OFF_ALT_TAG, 32'hc3a5_0f01);
    xfer(tin[0]);
    chk("abort_rst", 32'h3, {30'h0, to.abort, to.bypassed});
    $display("reset and default abort test done");
    for (int i = 0; i < 5; i++) begin
      cap = (i != 4);
      acc(1'b1, 1'b1, `SBI_OFF_BYPASS, bps[i] | 32'h8000_0000);
      rchk("bypass", `SBI_OFF_BYPASS, bps[i]);
      xfer(tin[i]);
      chk("attr", 32'(exp_attr(bps[i], tin[i], cap)), 32'(to.attr));
      chk("bypassed", 32'h1, {30'h0, to.abort, to.bypassed});
      chk("tag", 32'hc3a5_0f01, to.implementation_tag);
    end
    te = 1'b1;
    xfer(tin[0]);
    chk("te_attr", 32'(tin[0].attr), 32'(to.attr));
    te = 1'b0;
    xfer(14'h06a0);
    chk("ns_stream", 32'h0, {30'h0, to.abort, to.bypassed});
    $display("bypass attribute test done");
    @(posedge clk);
    #1 {rv, rw, rs, ra, wd} = {1'b1, 1'b1, 1'b1, `SBI_OFF_BYPASS, 32'h8000_0e00};
    @(posedge clk);
    #1 wd = 32'h0010_0000;
    @(posedge clk);
    #1 rv = 1'b0;
    rchk("bypass_ro", `SBI_OFF_BYPASS, 32'h0000_0e00);
    acc(1'b1, 1'b1, `SBI_OFF_IRQ_EN, 32'hffff_ffff);
    chk("irq_early", 32'h0, {30'h0, eqe, gee});
    @(posedge clk);
    #1 chk("irq_out", 32'h3, {30'h0, eqe, gee});
    rchk("irq_ctrl", `SBI_OFF_IRQ_EN, 32'h5);
    rchk("irq_ack", `SBI_OFF_IRQ_ACK, 32'h5);
    acc(1'b1, 1'b0, `SBI_OFF_IRQ_EN, 32'h0);
    rchk("ns_write", `SBI_OFF_IRQ_EN, 32'h5);
    acc(1'b0, 1'b0, `SBI_OFF_IRQ_EN, 32'h0);
    chk("ns_read", 32'h0, got);
    acc(1'b1, 1'b1, `SBI_OFF_IRQ_ACK, 32'h0);
    rchk("ack_ro", `SBI_OFF_IRQ_ACK, 32'h5);
    $display("read-only and interrupt enable test done");
    final_report;
  end
endmodule
